//--- hdl/bbd_consts.svh
// timing counts, opcode patterns and reset values of the branch/bit/control decoder
`ifndef BBD_CONSTS_SVH
`define BBD_CONSTS_SVH

`define BBD_PC_W          12
`define BBD_RESET_PC      12'h000
`define BBD_STACK_DEPTH   6

// instruction lengths in bytes
`define BBD_SHORT_BYTES   12'h001
`define BBD_BITTEST_BYTES 12'h003
`define BBD_BITOP_BYTES   12'h002
`define BBD_LONG_BYTES    12'h002
`define BBD_CTRL_BYTES    12'h001

// reach offsets of the two relative forms, added before the signed displacement
`define BBD_SHORT_BIAS    12'h001
`define BBD_BITTEST_BIAS  12'h002

// last cycle index of each instruction (cycle count minus one)
`define BBD_LAST_SHORT    3'h1
`define BBD_LAST_BITTEST  3'h4
`define BBD_LAST_BITOP    3'h3
`define BBD_LAST_LONG     3'h3
`define BBD_LAST_CTRL     3'h1

// low bits of the opcode that select each group
`define BBD_LO3_NONZERO   3'h0
`define BBD_LO3_ZERO      3'h4
`define BBD_LO3_NOCARRY   3'h2
`define BBD_LO3_CARRY     3'h6
`define BBD_LO4_CALL      4'h1
`define BBD_LO4_JUMP      4'h9
`define BBD_LO4_BITTEST   4'h3
`define BBD_LO4_BITOP     4'hb
`define BBD_LO4_HOLE      4'h5

// whole control opcodes
`define BBD_OP_IRET       8'h4d
`define BBD_OP_STOP       8'h6d
`define BBD_OP_NOP        8'had
`define BBD_OP_RET        8'hcd
`define BBD_OP_WAIT       8'hed

// lone illegal codes outside the low-nibble-5 hole
`define BBD_OP_ILL_A      8'h77
`define BBD_OP_ILL_B      8'h97
`define BBD_OP_ILL_C      8'hf7

`endif

//--- hdl/bbd_pkg.sv
// types shared by the branch/bit/control decoder and its environment
`include "bbd_consts.svh"

package bbd_pkg;

  typedef enum logic [1:0] {
    BBD_RUN,
    BBD_WAITING,
    BBD_STOPPED
  } bbd_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } bbd_dm_req_t;

  typedef struct packed {
    logic load;
    logic z;
    logic c;
  } bbd_flag_ld_t;

  typedef struct packed {
    bbd_mode_t                                   mode;
    logic                                        wait_mode;
    logic                                        stop_mode;
    logic [2:0]                                  cnt;
    logic [`BBD_PC_W-1:0]                        pc;
    logic [7:0]                                  op;
    logic [7:0]                                  disp;
    logic [`BBD_STACK_DEPTH-1:0][`BBD_PC_W-1:0]  stack;
    logic                                        flag_z;
    logic                                        flag_c;
    logic [`BBD_PC_W-1:0]                        pm_addr;
    bbd_dm_req_t                                 dm;
    logic                                        illegal_op;
    logic                                        foreign_op;
    logic                                        done;
  } bbd_state_t;

endpackage : bbd_pkg

//--- hdl/bbd_decoder.sv
// sequencer for conditional branch, bit set/clear, control and jump/call instructions
`timescale 1ns/100ps

module bbd_decoder (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            pm_rdata,
  output logic [`BBD_PC_W-1:0]       pm_addr,
  input  wire logic [7:0]            dm_rdata,
  output bbd_pkg::bbd_dm_req_t       dm_req,
  input  wire bbd_pkg::bbd_flag_ld_t flag_ld,
  input  wire logic                  shadow_z,
  input  wire logic                  shadow_c,
  input  wire logic                  wdg_sel,
  input  wire logic                  wake,
  output logic                       flag_z,
  output logic                       flag_c,
  output logic                       wait_mode,
  output logic                       stop_mode,
  output logic                       illegal_op,
  output logic                       foreign_op,
  output logic                       insn_done
);

  bbd_pkg::bbd_state_t r;
  bbd_pkg::bbd_state_t n;

  logic [2:0]            last;
  logic [`BBD_PC_W-1:0]  seq_pc;
  logic [`BBD_PC_W-1:0]  short_tgt;
  logic [`BBD_PC_W-1:0]  test_tgt;
  logic [2:0]            bit_sel;
  logic                  tested;
  logic                  is_short;
  logic                  short_cond;
  logic                  is_illegal;
  logic                  is_ctrl;

  always_comb
  begin
    bit_sel    = {r.op[5], r.op[6], r.op[7]};
    tested     = dm_rdata[bit_sel];
    short_tgt  = r.pc + `BBD_SHORT_BIAS + {{7{r.op[7]}}, r.op[7:3]};
    test_tgt   = r.pc + `BBD_BITTEST_BIAS + {{4{r.disp[7]}}, r.disp};
    is_short   = (r.op[0] == 1'b0);
    case (r.op[2:0])
      `BBD_LO3_NONZERO: short_cond = !r.flag_z;
      `BBD_LO3_ZERO:    short_cond = r.flag_z;
      `BBD_LO3_NOCARRY: short_cond = !r.flag_c;
      default:          short_cond = r.flag_c;
    endcase
    is_illegal = ((r.op[3:0] == `BBD_LO4_HOLE) && !r.op[4]) || (r.op == `BBD_OP_ILL_A)
                 || (r.op == `BBD_OP_ILL_B) || (r.op == `BBD_OP_ILL_C);
    is_ctrl    = (r.op == `BBD_OP_IRET) || (r.op == `BBD_OP_STOP) || (r.op == `BBD_OP_NOP)
                 || (r.op == `BBD_OP_RET) || (r.op == `BBD_OP_WAIT);
    if (is_short)
    begin
      last   = `BBD_LAST_SHORT;
      seq_pc = r.pc + `BBD_SHORT_BYTES;
    end
    else if (r.op[3:0] == `BBD_LO4_BITTEST)
    begin
      last   = `BBD_LAST_BITTEST;
      seq_pc = r.pc + `BBD_BITTEST_BYTES;
    end
    else if (r.op[3:0] == `BBD_LO4_BITOP)
    begin
      last   = `BBD_LAST_BITOP;
      seq_pc = r.pc + `BBD_BITOP_BYTES;
    end
    else if ((r.op[3:0] == `BBD_LO4_CALL) || (r.op[3:0] == `BBD_LO4_JUMP))
    begin
      last   = `BBD_LAST_LONG;
      seq_pc = r.pc + `BBD_LONG_BYTES;
    end
    else
    begin
      // control, illegal and other-group opcodes all step over one byte
      last   = `BBD_LAST_CTRL;
      seq_pc = r.pc + `BBD_CTRL_BYTES;
    end
  end

  always_comb
  begin
    n            = r;
    n.dm.we      = 1'b0;
    n.illegal_op = 1'b0;
    n.foreign_op = 1'b0;
    n.done       = 1'b0;
    case (r.mode)
      bbd_pkg::BBD_RUN:
      begin
        n.cnt = r.cnt + 3'h1;
        if (r.cnt == 3'h0)
        begin
          n.op      = pm_rdata;
          n.pm_addr = r.pc + 12'h001;
        end
        else if (r.cnt == 3'h1)
        begin
          // second byte: a data-space address or the low target byte
          n.dm.addr = pm_rdata;
          n.disp    = pm_rdata;
          n.pm_addr = r.pc + 12'h002;
        end
        else if ((r.cnt == 3'h2) && (r.op[3:0] == `BBD_LO4_BITTEST))
        begin
          // only the bit test owns a third byte; jump/call must keep their low target byte
          n.disp = pm_rdata;
        end
        if ((r.cnt != 3'h0) && (r.cnt == last))
        begin
          n.cnt     = 3'h0;
          n.done    = 1'b1;
          n.pc      = seq_pc;
          if (is_short)
          begin
            if (short_cond)
            begin
              n.pc = short_tgt;
            end
          end
          else if (r.op[3:0] == `BBD_LO4_BITTEST)
          begin
            n.flag_c = tested;
            if (tested == r.op[4])
            begin
              n.pc = test_tgt;
            end
          end
          else if (r.op[3:0] == `BBD_LO4_BITOP)
          begin
            // read-modify-write; the write lands while the address is still held
            n.dm.wdata          = dm_rdata;
            n.dm.wdata[bit_sel] = r.op[4];
            n.dm.we             = 1'b1;
          end
          else if ((r.op[3:0] == `BBD_LO4_CALL) || (r.op[3:0] == `BBD_LO4_JUMP))
          begin
            n.pc = {r.op[7:4], r.disp};
            if (r.op[3:0] == `BBD_LO4_CALL)
            begin
              // a full stack loses its oldest entry
              n.stack = {r.stack[`BBD_STACK_DEPTH-2:0], seq_pc};
            end
          end
          else if ((r.op == `BBD_OP_RET) || (r.op == `BBD_OP_IRET))
          begin
            n.pc    = r.stack[0];
            n.stack = {r.stack[0], r.stack[`BBD_STACK_DEPTH-1:1]};
            if (r.op == `BBD_OP_IRET)
            begin
              n.flag_z = shadow_z;
              n.flag_c = shadow_c;
            end
          end
          else if ((r.op == `BBD_OP_STOP) && !wdg_sel)
          begin
            n.mode      = bbd_pkg::BBD_STOPPED;
            n.stop_mode = 1'b1;
          end
          else if ((r.op == `BBD_OP_WAIT) || (r.op == `BBD_OP_STOP))
          begin
            n.mode      = bbd_pkg::BBD_WAITING;
            n.wait_mode = 1'b1;
          end
          else if (is_illegal)
          begin
            n.illegal_op = 1'b1;
          end
          else if (!is_ctrl)
          begin
            n.foreign_op = 1'b1;
          end
          n.pm_addr = n.pc;
        end
      end
      default:
      begin
        if (wake)
        begin
          n.mode      = bbd_pkg::BBD_RUN;
          n.wait_mode = 1'b0;
          n.stop_mode = 1'b0;
        end
      end
    endcase
    // an external flag load loses to an instruction's own flag update that changes z or c
    if (flag_ld.load && (n.flag_z == r.flag_z) && (n.flag_c == r.flag_c))
    begin
      n.flag_z = flag_ld.z;
      n.flag_c = flag_ld.c;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      r            <= '0;
      r.mode       <= bbd_pkg::BBD_RUN;
      r.pc         <= `BBD_RESET_PC;
      r.pm_addr    <= `BBD_RESET_PC;
    end
    else
    begin
      r <= n;
    end
  end

  assign pm_addr    = r.pm_addr;
  assign dm_req     = r.dm;
  assign flag_z     = r.flag_z;
  assign flag_c     = r.flag_c;
  assign wait_mode  = r.wait_mode;
  assign stop_mode  = r.stop_mode;
  assign illegal_op = r.illegal_op;
  assign foreign_op = r.foreign_op;
  assign insn_done  = r.done;

endmodule : bbd_decoder

//--- tb/bbd_mem_model.sv
// program and data memory seen by the decoder, combinational reads
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_mem_model (
  input  wire logic                 sys_clk,
  input  wire logic [`BBD_PC_W-1:0] pm_addr,
  output logic      [7:0]           pm_rdata,
  input  wire bbd_pkg::bbd_dm_req_t dm_req,
  output logic      [7:0]           dm_rdata
);
  logic [7:0] pm [0:4095];
  logic [7:0] dm [0:255];
  // unloaded program space runs as no-ops so a stray fetch stays harmless
  initial
  begin
    foreach (pm[i]) pm[i] = `BBD_OP_NOP;
    foreach (dm[i]) dm[i] = 8'h00;
  end
  assign pm_rdata = pm[pm_addr];
  assign dm_rdata = dm[dm_req.addr];
  always @(posedge sys_clk)
    if (dm_req.we)
      dm[dm_req.addr] <= dm_req.wdata;
endmodule : bbd_mem_model

//--- tb/bbd_decoder_sva.sv
// port assertions for the branch/bit/control decoder
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_decoder_chk (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic [`BBD_PC_W-1:0]  pm_addr,
  input wire bbd_pkg::bbd_dm_req_t  dm_req,
  input wire bbd_pkg::bbd_flag_ld_t flag_ld,
  input wire logic                  wdg_sel,
  input wire logic                  wake,
  input wire logic                  flag_z,
  input wire logic                  flag_c,
  input wire logic                  wait_mode,
  input wire logic                  stop_mode,
  input wire logic                  illegal_op,
  input wire logic                  foreign_op,
  input wire logic                  insn_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_done_pulse: assert property (insn_done |=> !insn_done)
    else $error("insn_done lasted two cycles");
  a_illegal_done: assert property (illegal_op |-> insn_done)
    else $error("illegal flag without completion");
  a_illegal_apart: assert property (!(illegal_op && foreign_op))
    else $error("illegal and foreign flagged together");
  a_write_pulse: assert property (dm_req.we |=> !dm_req.we)
    else $error("data write longer than one cycle");
  a_write_done: assert property (dm_req.we |-> insn_done)
    else $error("data write not in completion cycle");
  a_halt_excl: assert property (!(wait_mode && stop_mode))
    else $error("wait and stop both high");
  a_stop_wdg: assert property ($rose(stop_mode) |-> !$past(wdg_sel))
    else $error("stop entered with watchdog selected");
  a_halt_hold: assert property ((wait_mode || stop_mode) && !wake |=> $stable(pm_addr))
    else $error("fetch moved while halted");
  a_flags_quiet: assert property ((!flag_ld.load ##1 !insn_done) |-> $stable({flag_z, flag_c}))
    else $error("flags changed outside completion");
  c_write: cover property (dm_req.we);
  c_illegal: cover property (illegal_op);
  c_wait: cover property ($rose(wait_mode));
endmodule : bbd_decoder_chk

//--- tb/bbd_decoder_bench.sv
// self-checking bench running a short program through the decoder
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_decoder_bench;
  logic                  sys_clk, sys_rst, wdg_sel, wake, shadow_z, shadow_c;
  logic [7:0]            pm_rdata, dm_rdata;
  logic [`BBD_PC_W-1:0]  pm_addr;
  bbd_pkg::bbd_dm_req_t  dm_req;
  bbd_pkg::bbd_flag_ld_t flag_ld;
  logic                  flag_z, flag_c, wait_mode, stop_mode, illegal_op, foreign_op, insn_done;
  int                    bad_count, cmp_count;

  bbd_mem_model bbd_mem_model_inst (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_rdata(dm_rdata));
  bbd_decoder bbd_decoder_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .pm_rdata(pm_rdata),
    .pm_addr(pm_addr), .dm_rdata(dm_rdata), .dm_req(dm_req), .flag_ld(flag_ld),
    .shadow_z(shadow_z), .shadow_c(shadow_c), .wdg_sel(wdg_sel), .wake(wake), .flag_z(flag_z),
    .flag_c(flag_c), .wait_mode(wait_mode), .stop_mode(stop_mode), .illegal_op(illegal_op),
    .foreign_op(foreign_op), .insn_done(insn_done));

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // cycles of 0 skips the length check where a halt stretches the count
  task automatic step(input logic [11:0] exp_addr, input int cycles);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (insn_done !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      bad_count++;
      test_done();
    end
    check("pm_addr", pm_addr, exp_addr);
    if (cycles > 0)
      check("cycles", n[11:0], cycles[11:0]);
  endtask : step

  task automatic t_short();
    step(12'h004, 2);
    step(12'h005, 2);
  endtask : t_short

  task automatic t_bits();
    step(12'h007, 4);
    // memory takes the write one edge after completion, so judge the request here
    check("data write", {3'h0, dm_req.we, dm_req.wdata}, 12'h104);
    step(12'h019, 5);
    check("data byte", {4'h0, bbd_mem_model_inst.dm[8'h40]}, 12'h004);
    check("carry", flag_c, 12'h001);
    step(12'h01c, 5);
    step(12'h00e, 2);
    check("zero", flag_z, 12'h000);
  endtask : t_bits

  task automatic t_jump();
    step(12'h3ab, 4);
    step(12'h3ac, 2);
    check("illegal", illegal_op, 12'h001);
  endtask : t_jump

  task automatic t_halt();
    step(12'h3ad, 2);
    check("wait", wait_mode, 12'h001);
    repeat (3) @(posedge sys_clk);
    wdg_sel <= 1'b0;
    #1;
    check("held", pm_addr, 12'h3ad);
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    step(12'h3ae, 0);
    check("stop", {stop_mode, wait_mode}, 12'h002);
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    step(12'h3af, 0);
  endtask : t_halt

  // call, iret restoring shadow flags, a foreign opcode, call and plain return
  task automatic t_call();
    step(12'h500, 4);
    step(12'h3b1, 2);
    check("flags", {flag_z, flag_c}, 12'h002);
    step(12'h3b2, 2);
    check("foreign", foreign_op, 12'h001);
    check("not illegal", illegal_op, 12'h000);
    step(12'h600, 4);
    step(12'h3b4, 2);
    check("flags kept", {flag_z, flag_c}, 12'h002);
  endtask : t_call

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    sys_rst = 1'b1;
    wdg_sel = 1'b1;
    wake = 1'b0;
    shadow_z = 1'b1;
    shadow_c = 1'b0;
    flag_ld = '0;
    @(posedge sys_clk);
    // short branches, bit set, two bit tests, carry branch back by 15, jump, illegal, stops
    bbd_mem_model_inst.pm[12'h000] = 8'h18;
    bbd_mem_model_inst.pm[12'h004] = 8'h2c;
    {bbd_mem_model_inst.pm[12'h005], bbd_mem_model_inst.pm[12'h006]} = 16'h5b40;
    {bbd_mem_model_inst.pm[12'h007], bbd_mem_model_inst.pm[12'h008]} = 16'h5340;
    bbd_mem_model_inst.pm[12'h009] = 8'h10;
    {bbd_mem_model_inst.pm[12'h019], bbd_mem_model_inst.pm[12'h01a]} = 16'h4340;
    bbd_mem_model_inst.pm[12'h01b] = 8'h80;
    bbd_mem_model_inst.pm[12'h01c] = 8'h8e;
    {bbd_mem_model_inst.pm[12'h00e], bbd_mem_model_inst.pm[12'h00f]} = 16'h39ab;
    bbd_mem_model_inst.pm[12'h3ab] = `BBD_OP_ILL_A;
    bbd_mem_model_inst.pm[12'h3ac] = `BBD_OP_STOP;
    bbd_mem_model_inst.pm[12'h3ad] = `BBD_OP_STOP;
    {bbd_mem_model_inst.pm[12'h3af], bbd_mem_model_inst.pm[12'h3b0]} = 16'h5100;
    bbd_mem_model_inst.pm[12'h500] = `BBD_OP_IRET;
    bbd_mem_model_inst.pm[12'h3b1] = 8'h07;
    {bbd_mem_model_inst.pm[12'h3b2], bbd_mem_model_inst.pm[12'h3b3]} = 16'h6100;
    bbd_mem_model_inst.pm[12'h600] = `BBD_OP_RET;
    repeat (19) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_short();
    t_bits();
    t_jump();
    t_halt();
    t_call();
    test_done();
  end
endmodule : bbd_decoder_bench

bind bbd_decoder bbd_decoder_chk bbd_decoder_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .pm_addr(pm_addr), .dm_req(dm_req), .flag_ld(flag_ld), .wdg_sel(wdg_sel), .wake(wake),
  .flag_z(flag_z), .flag_c(flag_c), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .illegal_op(illegal_op), .foreign_op(foreign_op), .insn_done(insn_done));
